// ### rtl/cwd_pkg.sv
// constants for the countdown watchdog timer
// assumes a 250 MHz core clock and an APB register bus with 32-bit data
package cwd_pkg;
   // register byte offsets
   localparam logic [11:0] CWD_OFS_START      = 12'h000;
   localparam logic [11:0] CWD_OFS_TIMEOUT    = 12'h100;
   localparam logic [11:0] CWD_OFS_INT_SET    = 12'h304;
   localparam logic [11:0] CWD_OFS_INT_CLR    = 12'h308;
   localparam logic [11:0] CWD_OFS_RUN_STAT   = 12'h400;
   localparam logic [11:0] CWD_OFS_REQ_STAT   = 12'h404;
   localparam logic [11:0] CWD_OFS_RELOAD_VAL = 12'h504;
   localparam logic [11:0] CWD_OFS_RREQ_EN    = 12'h508;
   localparam logic [11:0] CWD_OFS_CONFIG     = 12'h50C;
   localparam logic [11:0] CWD_OFS_RREQ_BASE  = 12'h600;
   localparam logic [11:0] CWD_OFS_RREQ_LAST  = 12'h61C;
   localparam logic [11:0] CWD_OFS_SLEEP_IN   = 12'h700;
   // field positions
   localparam int          CWD_CFG_SLEEP_BIT  = 0;
   localparam int          CWD_CFG_HALT_BIT   = 3;
   // reset values and keys
   localparam logic [31:0] CWD_RELOAD_RST     = 32'hFFFFFFFF;
   localparam logic [7:0]  CWD_RREQ_EN_RST    = 8'h01;
   localparam logic [31:0] CWD_RELOAD_KEY     = 32'h6E524635;
   // timing
   localparam longint      CWD_CORE_HZ        = 64'd250000000;
   localparam longint      CWD_SLOW_HZ        = 64'd32768;
   localparam int          CWD_SLOW_DIV       = int'(CWD_CORE_HZ / CWD_SLOW_HZ);
   localparam int          CWD_RESET_DELAY    = 2;
endpackage

// ### rtl/cwd_tick_gen.sv
// slow clock tick generator: one-cycle enable every DIV core cycles
// assumes a single core clock domain
`timescale 1ns/1ps
`default_nettype none
module cwd_tick_gen #(
   parameter int DIV = 7629
) (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_b_i,
   // tick out
   output logic      tick_o
);
   initial begin
      if (DIV < 2) $error("cwd_tick_gen: DIV must be at least 2");
   end

   localparam int          CW     = $clog2(DIV);
   localparam logic [CW-1:0] TOP = CW'(DIV - 1);

   logic [CW-1:0] cnt_q;
   wire           wrap = (cnt_q == TOP);

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_q  <= '0;
         tick_o <= 1'b0;
      end else begin
         cnt_q  <= wrap ? '0 : cnt_q + 1'b1;
         tick_o <= wrap;
      end
   end
endmodule
`default_nettype wire

// ### rtl/cwd_watchdog.sv
// countdown watchdog timer top: APB slave, down-counter, reload logic, reset request
// assumes APB master on CORE_CLK_I; sleep and halt levels arrive from other clock domains
`timescale 1ns/1ps
`default_nettype none
module cwd_watchdog
   import cwd_pkg::*;
#(
   parameter int SLOW_DIV = CWD_SLOW_DIV,
   parameter int NUM_RREQ = 8
) (
   // clock and reset
   input  wire logic        CORE_CLK_I,
   input  wire logic        RST_B_I,
   // apb slave
   input  wire logic        PSEL_I,
   input  wire logic        PENABLE_I,
   input  wire logic        PWRITE_I,
   input  wire logic [11:0] PADDR_I,
   input  wire logic [31:0] PWDATA_I,
   output logic [31:0]      PRDATA_O,
   output logic             PREADY_O,
   output logic             PSLVERR_O,
   // system status in
   input  wire logic        CPU_SLEEP_I,
   input  wire logic        DEBUG_HALT_I,
   input  wire logic        SLOW_SRC_RUNNING_I,
   // system control out
   output logic             RC_OSC_FORCE_O,
   output logic             TIMEOUT_IRQ_O,
   output logic             WDOG_RESET_REQ_O
);
   initial begin
      if (NUM_RREQ != 8) $error("cwd_watchdog: NUM_RREQ must be 8");
   end

   // slow clock enable
   logic slow_tick;
   cwd_tick_gen #(.DIV(SLOW_DIV)) u_tick (
      .clk_i   (CORE_CLK_I),
      .rst_b_i (RST_B_I),
      .tick_o  (slow_tick)
   );

   // three-stage sync for foreign levels
   logic [2:0] sleep_sy_q;
   logic [2:0] halt_sy_q;
   logic [2:0] src_sy_q;
   logic       sleep_q;
   logic       halt_q;
   logic       src_q;

   always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         sleep_sy_q <= 3'h0;
         halt_sy_q  <= 3'h0;
         src_sy_q   <= 3'h0;
         sleep_q    <= 1'b0;
         halt_q     <= 1'b0;
         src_q      <= 1'b0;
      end else begin
         sleep_sy_q <= {sleep_sy_q[1:0], CPU_SLEEP_I};
         halt_sy_q  <= {halt_sy_q[1:0], DEBUG_HALT_I};
         src_sy_q   <= {src_sy_q[1:0], SLOW_SRC_RUNNING_I};
         if (sleep_sy_q[2] == sleep_sy_q[1]) sleep_q <= sleep_sy_q[2];
         if (halt_sy_q[2] == halt_sy_q[1])   halt_q  <= halt_sy_q[2];
         if (src_sy_q[2] == src_sy_q[1])     src_q   <= src_sy_q[2];
      end
   end

   // state
   logic [31:0]         reload_value_q;
   logic [NUM_RREQ-1:0] reload_request_enable_q;
   logic                pause_sleep_q;
   logic                pause_halt_q;
   logic                int_en_q;
   logic                running_q;
   logic [31:0]         count_q;
   logic [NUM_RREQ-1:0] key_seen_q;
   logic                timeout_ev_q;
   logic                rst_pend_q;
   logic [1:0]          rst_dly_q;
   logic                wdog_rst_q;
   logic [31:0]         prdata_q;

   // bus decode
   wire       acc       = PSEL_I && PENABLE_I;
   wire       wr        = acc && PWRITE_I;
   wire       rd        = acc && !PWRITE_I;
   wire       cfg_open  = !running_q;
   wire       in_rreq   = (PADDR_I >= CWD_OFS_RREQ_BASE) && (PADDR_I <= CWD_OFS_RREQ_LAST)
                          && (PADDR_I[1:0] == 2'b00);
   wire [2:0] rreq_idx  = PADDR_I[4:2];
   wire       key_ok    = (PWDATA_I == CWD_RELOAD_KEY);
   wire       wr_start  = wr && (PADDR_I == CWD_OFS_START) && PWDATA_I[0];
   wire       wr_tmo    = wr && (PADDR_I == CWD_OFS_TIMEOUT);
   wire       wr_iset   = wr && (PADDR_I == CWD_OFS_INT_SET) && PWDATA_I[0];
   wire       wr_iclr   = wr && (PADDR_I == CWD_OFS_INT_CLR) && PWDATA_I[0];
   wire       wr_rval   = wr && (PADDR_I == CWD_OFS_RELOAD_VAL) && cfg_open;
   wire       wr_reload_request_enable   = wr && (PADDR_I == CWD_OFS_RREQ_EN) && cfg_open;
   wire       wr_cfg    = wr && (PADDR_I == CWD_OFS_CONFIG) && cfg_open;
   wire       wr_key    = wr && in_rreq && key_ok && running_q
                          && reload_request_enable_q[rreq_idx];
   wire       mapped    = (PADDR_I == CWD_OFS_START) || (PADDR_I == CWD_OFS_TIMEOUT)
                          || (PADDR_I == CWD_OFS_INT_SET) || (PADDR_I == CWD_OFS_INT_CLR)
                          || (PADDR_I == CWD_OFS_RUN_STAT) || (PADDR_I == CWD_OFS_REQ_STAT)
                          || (PADDR_I == CWD_OFS_RELOAD_VAL) || (PADDR_I == CWD_OFS_RREQ_EN)
                          || (PADDR_I == CWD_OFS_CONFIG) || in_rreq;

   // reload qualification
   wire [NUM_RREQ-1:0] key_seen_d = key_seen_q
                                    | (wr_key ? NUM_RREQ'(1) << rreq_idx : '0);
   wire grant = running_q
                && ((key_seen_d & reload_request_enable_q) == reload_request_enable_q);

   // pause control
   wire paused = (pause_sleep_q && sleep_q) || (pause_halt_q && halt_q);
   wire step   = running_q && slow_tick && !paused;
   wire wrap   = step && (count_q == 32'h0);

   // read mux
   logic [31:0] rdata;
   always_comb begin
      rdata = 32'h0;
      if (in_rreq) begin
         rdata = 32'h0;
      end else begin
         unique case (PADDR_I)
            CWD_OFS_TIMEOUT:    rdata = {31'h0, timeout_ev_q};
            CWD_OFS_INT_SET:    rdata = {31'h0, int_en_q};
            CWD_OFS_INT_CLR:    rdata = {31'h0, int_en_q};
            CWD_OFS_RUN_STAT:   rdata = {31'h0, running_q};
            CWD_OFS_REQ_STAT:   rdata = {24'h0, reload_request_enable_q & ~key_seen_q};
            CWD_OFS_RELOAD_VAL: rdata = reload_value_q;
            CWD_OFS_RREQ_EN:    rdata = {24'h0, reload_request_enable_q};
            CWD_OFS_CONFIG:     rdata = {28'h0, pause_halt_q, 2'b00, pause_sleep_q};
            default:            rdata = 32'h0;
         endcase
      end
   end

   // configuration, unlocked only by reset; interrupt enable stays writable while running
   always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         reload_value_q          <= CWD_RELOAD_RST;
         reload_request_enable_q <= CWD_RREQ_EN_RST;
         pause_sleep_q           <= 1'b0;
         pause_halt_q            <= 1'b0;
         int_en_q                <= 1'b0;
      end else begin
         if (wr_rval) reload_value_q <= PWDATA_I;
         if (wr_reload_request_enable) reload_request_enable_q <= PWDATA_I[NUM_RREQ-1:0];
         if (wr_cfg) begin
            pause_sleep_q <= PWDATA_I[CWD_CFG_SLEEP_BIT];
            pause_halt_q  <= PWDATA_I[CWD_CFG_HALT_BIT];
         end
         if (wr_iset) int_en_q <= 1'b1;
         else if (wr_iclr) int_en_q <= 1'b0;
      end
   end

   // run state and counter
   always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         running_q  <= 1'b0;
         count_q    <= CWD_RELOAD_RST;
         key_seen_q <= '0;
      end else begin
         if (wr_start && !running_q) begin
            running_q <= 1'b1;
            count_q   <= reload_value_q;
            key_seen_q <= '0;
         end else if (grant) begin
            count_q    <= reload_value_q;
            key_seen_q <= '0;
         end else begin
            key_seen_q <= key_seen_d;
            if (step) count_q <= count_q - 32'h1;
         end
      end
   end

   // timeout event and reset sequencing
   always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         timeout_ev_q <= 1'b0;
         rst_pend_q   <= 1'b0;
         rst_dly_q    <= 2'h0;
         wdog_rst_q   <= 1'b0;
      end else begin
         if (wrap) timeout_ev_q <= 1'b1;
         else if (wr_tmo && !PWDATA_I[0]) timeout_ev_q <= 1'b0;
         if (wrap && !rst_pend_q) begin
            rst_pend_q <= 1'b1;
            rst_dly_q  <= int_en_q ? 2'(CWD_RESET_DELAY) : 2'h0;
            if (!int_en_q) wdog_rst_q <= 1'b1;
         end else if (rst_pend_q && !wdog_rst_q && slow_tick) begin
            if (rst_dly_q <= 2'h1) wdog_rst_q <= 1'b1;
            rst_dly_q <= rst_dly_q - 2'h1;
         end
      end
   end

   always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) prdata_q <= 32'h0;
      else if (PSEL_I && !PENABLE_I && !PWRITE_I) prdata_q <= 32'h0;
      else if (rd) prdata_q <= rdata;
   end

   // outputs
   assign PRDATA_O         = rd ? rdata : prdata_q;
   assign PREADY_O         = 1'b1;
   assign PSLVERR_O        = acc && !mapped;
   assign RC_OSC_FORCE_O   = running_q && !src_q;
   assign TIMEOUT_IRQ_O    = timeout_ev_q && int_en_q;
   assign WDOG_RESET_REQ_O = wdog_rst_q;
endmodule
`default_nettype wire

// ### tb/cwd_watchdog_props.sv
// port checker for the countdown watchdog, bound to its top
// assumes a short slow tick divider handed on from the instance
`timescale 1ns/1ps
`default_nettype none
module cwd_watchdog_props
   import cwd_pkg::*;
#(
   parameter int SLOW_DIV = 4
) (
   // clock and reset
   input wire logic        CORE_CLK_I,
   input wire logic        RST_B_I,
   // apb
   input wire logic        PSEL_I,
   input wire logic        PENABLE_I,
   input wire logic        PWRITE_I,
   input wire logic [11:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   input wire logic [31:0] PRDATA_O,
   // system
   input wire logic        SLOW_SRC_RUNNING_I,
   input wire logic        RC_OSC_FORCE_O,
   input wire logic        TIMEOUT_IRQ_O,
   input wire logic        WDOG_RESET_REQ_O
);
   localparam int RST_MAX = 2 * SLOW_DIV + 4;
   wire logic wr = PSEL_I && PENABLE_I && PWRITE_I;
   wire logic rd = PSEL_I && PENABLE_I && !PWRITE_I;
   wire logic st = wr && PADDR_I == CWD_OFS_START && PWDATA_I[0];
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (!RST_B_I);
   a_reset_sticky: assert property (WDOG_RESET_REQ_O |=> WDOG_RESET_REQ_O)
      else $error("reset request dropped");
   a_osc_yield: assert property (SLOW_SRC_RUNNING_I[*6] |-> !RC_OSC_FORCE_O)
      else $error("oscillator forced beside other source");
   a_start_forces: assert property (((!SLOW_SRC_RUNNING_I)[*6] ##0 st) |-> ##[1:2] RC_OSC_FORCE_O)
      else $error("start did not force oscillator");
   a_run_holds: assert property (RC_OSC_FORCE_O && !SLOW_SRC_RUNNING_I |=> RC_OSC_FORCE_O)
      else $error("running watchdog stopped");
   a_irq_to_reset: assert property ($rose(TIMEOUT_IRQ_O) |-> ##[1:RST_MAX] WDOG_RESET_REQ_O)
      else $error("timeout without reset");
   a_irq_delay: assert property ($rose(TIMEOUT_IRQ_O) && !WDOG_RESET_REQ_O |-> !WDOG_RESET_REQ_O[*5])
      else $error("reset not postponed");
   a_rreq_read_zero: assert property (rd && PADDR_I >= CWD_OFS_RREQ_BASE && PADDR_I <= CWD_OFS_RREQ_LAST |-> PRDATA_O == 32'h0)
      else $error("request register read not zero");
   a_irq_drop: assert property ($fell(TIMEOUT_IRQ_O) |-> $past(wr))
      else $error("interrupt fell without a write");
   c_reset: cover property ($rose(WDOG_RESET_REQ_O));
   c_irq: cover property ($rose(TIMEOUT_IRQ_O));
   c_start: cover property (st);
endmodule
bind cwd_watchdog cwd_watchdog_props #(.SLOW_DIV(SLOW_DIV)) u_props (
   .CORE_CLK_I(CORE_CLK_I), .RST_B_I(RST_B_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
   .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
   .SLOW_SRC_RUNNING_I(SLOW_SRC_RUNNING_I), .RC_OSC_FORCE_O(RC_OSC_FORCE_O),
   .TIMEOUT_IRQ_O(TIMEOUT_IRQ_O), .WDOG_RESET_REQ_O(WDOG_RESET_REQ_O)
);
`default_nettype wire

// ### tb/cwd_watchdog_test.sv
// self-checking bench for the countdown watchdog
// assumes zero-wait apb answers and a slow tick every 4 core cycles
`timescale 1ns/1ps
`default_nettype none
module cwd_watchdog_test;
   import cwd_pkg::*;
   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        psel = 1'b0;
   logic        pen = 1'b0;
   logic        pwr = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic        slp = 1'b0;
   logic        hlt = 1'b0;
   logic        src = 1'b0;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, osc, irq, wrst, er, rdy;
   int          failures = 0;
   int          cmp_count = 0;
   int          n;
   // address, read data, error
   logic [44:0] rows [8] = '{{CWD_OFS_TIMEOUT, 32'h0, 1'b0}, {CWD_OFS_INT_SET, 32'h0, 1'b0},
      {CWD_OFS_RUN_STAT, 32'h0, 1'b0}, {CWD_OFS_RELOAD_VAL, 32'hFFFFFFFF, 1'b0},
      {CWD_OFS_RREQ_EN, 32'h1, 1'b0}, {CWD_OFS_CONFIG, 32'h0, 1'b0},
      {CWD_OFS_RREQ_BASE, 32'h0, 1'b0}, {CWD_OFS_SLEEP_IN, 32'h0, 1'b1}};
   cwd_watchdog #(.SLOW_DIV(4)) i_cwd_watchdog (
      .CORE_CLK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(pen),
      .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
      .PREADY_O(pready), .PSLVERR_O(pslverr), .CPU_SLEEP_I(slp), .DEBUG_HALT_I(hlt),
      .SLOW_SRC_RUNNING_I(src), .RC_OSC_FORCE_O(osc), .TIMEOUT_IRQ_O(irq),
      .WDOG_RESET_REQ_O(wrst));
   always #2 clk = ~clk;
   task automatic chk_word(input logic [31:0] g, e);
      cmp_count++;
      if (g !== e) begin
         failures++;
         $display("FAIL %0t word %h expected %h", $time, g, e);
      end
   endtask
   task automatic chk_bit(input logic g, e);
      cmp_count++;
      if (g !== e) begin
         failures++;
         $display("FAIL %0t bit %b expected %b", $time, g, e);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      // request stands until pready is seen high at a rising edge
      do begin
         @(posedge clk);
         rdy = pready;
         rd = prdata;
         er = pslverr;
      end while (rdy !== 1'b1);
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask
   task automatic do_reset();
      rst_b <= 1'b0;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
   endtask
   // cycles until the reset request shows, ends on a rising edge
   task automatic wait_rst(input int lim);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (wrst !== 1'b1 && n < lim);
      @(posedge clk);
   endtask
   task automatic wrap_up();
      if (failures == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      wrap_up();
   end
   initial begin
      do_reset();
      for (int i = 0; i < 8; i++) begin
         apb(1'b0, rows[i][44:33], 32'h0);
         if (!rows[i][0]) chk_word(rd, rows[i][32:1]);
         chk_bit(er, rows[i][0]);
      end
      apb(1'b1, CWD_OFS_RELOAD_VAL, 32'd40);
      apb(1'b1, CWD_OFS_RREQ_EN, 32'h5);
      apb(1'b1, CWD_OFS_START, 32'h1);
      apb(1'b1, CWD_OFS_RELOAD_VAL, 32'd7);
      apb(1'b0, CWD_OFS_RELOAD_VAL, 32'h0);
      chk_word(rd, 32'd40);
      apb(1'b0, CWD_OFS_RUN_STAT, 32'h0);
      chk_word(rd, 32'h1);
      chk_bit(osc, 1'b1);
      apb(1'b1, CWD_OFS_RREQ_BASE, CWD_RELOAD_KEY);
      apb(1'b1, CWD_OFS_RREQ_BASE + 12'h008, 32'h1);
      apb(1'b0, CWD_OFS_REQ_STAT, 32'h0);
      chk_word(rd, 32'h4);
      repeat (6) begin
         apb(1'b1, CWD_OFS_RREQ_BASE + 12'h008, CWD_RELOAD_KEY);
         apb(1'b0, CWD_OFS_REQ_STAT, 32'h0);
         chk_word(rd, 32'h5);
         apb(1'b1, CWD_OFS_RREQ_BASE, CWD_RELOAD_KEY);
         repeat (100) @(posedge clk);
      end
      chk_bit(wrst, 1'b0);
      apb(1'b1, CWD_OFS_RREQ_BASE + 12'h008, CWD_RELOAD_KEY);
      wait_rst(400);
      chk_bit(n >= 155 && n <= 172, 1'b1);
      apb(1'b0, CWD_OFS_TIMEOUT, 32'h0);
      chk_word(rd, 32'h1);
      do_reset();
      apb(1'b1, CWD_OFS_RELOAD_VAL, 32'd3);
      apb(1'b0, CWD_OFS_RELOAD_VAL, 32'h0);
      chk_word(rd, 32'd3);
      apb(1'b1, CWD_OFS_CONFIG, 32'h1);
      apb(1'b1, CWD_OFS_INT_SET, 32'h1);
      apb(1'b0, CWD_OFS_INT_SET, 32'h0);
      chk_word(rd, 32'h1);
      slp <= 1'b1;
      hlt <= 1'b1;
      src <= 1'b1;
      repeat (10) @(posedge clk);
      apb(1'b1, CWD_OFS_START, 32'h1);
      repeat (200) @(posedge clk);
      chk_bit(wrst, 1'b0);
      chk_bit(osc, 1'b0);
      slp <= 1'b0;
      wait_rst(100);
      chk_bit(n >= 16 && n <= 36, 1'b1);
      apb(1'b1, CWD_OFS_INT_CLR, 32'h1);
      chk_bit(irq, 1'b0);
      chk_bit(wrst, 1'b1);
      wrap_up();
   end
endmodule
`default_nettype wire
